// ==== logic/clc_checker.sv ====
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
// Functional notes
// - CRC uses fixed polynomial x^16+x^15+x^2+1, constant 0x8005.
// - each step takes one input byte and yields a 16-bit result.
// - CRC for a written byte is done in one clock cycle.
// - order bit 0 feeds MSB first; 1 feeds LSB first.
// - bit order affects only input bytes, never result or start value.
// - writing 1 to wipe bit zeroes CRC; bit pulses one cycle, reads 0.
// - writing zero to the CRC result register also clears it.
// - writing the CRC result register sets the next start value.
// - without load or wipe, previous result seeds the next byte.
// - each input byte write with byte lane 0 strobed updates the CRC result register.
// - an 8-bit LRC is formed from the same input bytes.
// - LRC and CRC update together and read independently.
// - with order bit 0, matches width 16, init 0, xorout 0, no reflection model.
// - control, input and result registers take 8, 16, 32-bit writes.
// - each input byte is XORed into the LRC register.
module clc_checker (
   input  wire logic                        mclk,
   input  wire logic                        resetn,
   input  wire logic [clc_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [clc_pkg::DATA_W-1:0]  wdata,
   input  wire logic [clc_pkg::STRB_W-1:0]  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [clc_pkg::ADDR_W-1:0]  araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [clc_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready
);
   import clc_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic clc_sel_t clc_decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'h0};
      case (w)
         OFS_CHECKSUM_CONTROL:    return SEL_CONTROL;
         OFS_CHECKSUM_INPUT_BYTE: return SEL_INPUT;
         OFS_CRC_RESULT_VALUE:    return SEL_CRC;
         OFS_LRC_RESULT_VALUE:    return SEL_LRC;
         default:                 return SEL_NONE;
      endcase
   endfunction

   // one byte through the shift register, msb or lsb first
   function automatic logic [CRC_W-1:0] clc_crc_byte(input logic [CRC_W-1:0]  c,
                                                     input logic [BYTE_W-1:0] d,
                                                     input logic              lsb_first);
      logic [CRC_W-1:0] r;
      logic             fb;
      r = c;
      for (int i = 0; i < BYTE_W; i++) begin
         fb = r[CRC_W-1] ^ (lsb_first ? d[i] : d[BYTE_W-1-i]);
         r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RESET);
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic                awready_reg;
   logic                wready_reg;
   logic                bvalid_reg;
   logic [1:0]          bresp_reg;
   logic                arready_reg;
   logic                rvalid_reg;
   logic [1:0]          rresp_reg;
   logic [DATA_W-1:0]   rdata_reg;
   logic                aw_held_reg;
   logic                w_held_reg;
   logic [ADDR_W-1:0]   awaddr_reg;
   logic [DATA_W-1:0]   wdata_reg;
   logic [STRB_W-1:0]   wstrb_reg;
   logic                order_reg;
   logic                wipe_reg;
   logic [BYTE_W-1:0]   byte_reg;
   logic [CRC_W-1:0]    crc_reg;
   logic [BYTE_W-1:0]   lrc_reg;

   // ----------------------------------------------------------------
   // write channel decode
   // ----------------------------------------------------------------
   wire                 aw_take      = awvalid & awready_reg;
   wire                 w_take       = wvalid & wready_reg;
   wire                 commit       = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire clc_sel_t       wsel         = clc_decode(awaddr_reg);
   wire                 ctrl_wr      = commit & (wsel == SEL_CONTROL) & wstrb_reg[0];
   wire                 data_wr      = commit & (wsel == SEL_INPUT) & wstrb_reg[0];
   wire                 crc_lo_wr    = commit & (wsel == SEL_CRC) & wstrb_reg[0];
   wire                 crc_hi_wr    = commit & (wsel == SEL_CRC) & wstrb_reg[1];
   wire                 lrc_wr       = commit & (wsel == SEL_LRC) & wstrb_reg[0];
   wire                 wipe_wr      = ctrl_wr & wdata_reg[WIPE_BIT];
   wire [BYTE_W-1:0]    in_byte      = wdata_reg[BYTE_W-1:0];
   wire [CRC_W-1:0]     crc_calc     = clc_crc_byte(crc_reg, in_byte, order_reg);
   wire [BYTE_W-1:0]    lrc_calc     = lrc_reg ^ in_byte;
   wire [CRC_W-1:0]     crc_load     = {crc_hi_wr ? wdata_reg[CRC_W-1:BYTE_W] : crc_reg[CRC_W-1:BYTE_W],
                                        crc_lo_wr ? wdata_reg[BYTE_W-1:0] : crc_reg[BYTE_W-1:0]};
   wire                 crc_touch    = wipe_wr | data_wr | crc_lo_wr | crc_hi_wr;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   wire                 aw_held_next = (aw_held_reg & ~commit) | aw_take;
   wire                 w_held_next  = (w_held_reg & ~commit) | w_take;
   wire                 bvalid_next  = commit | (bvalid_reg & ~bready);
   wire [1:0]           bresp_next   = commit ? ((wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY)
                                              : bresp_reg;
   wire [ADDR_W-1:0]    awaddr_next  = aw_take ? awaddr : awaddr_reg;
   wire [DATA_W-1:0]    wdata_next   = w_take ? wdata : wdata_reg;
   wire [STRB_W-1:0]    wstrb_next   = w_take ? wstrb : wstrb_reg;
   wire                 order_next   = ctrl_wr ? wdata_reg[ORDER_BIT] : order_reg;
   wire [BYTE_W-1:0]    byte_next    = data_wr ? in_byte : byte_reg;
   // wipe first, then a new byte, then a direct load; else hold
   wire [CRC_W-1:0]     crc_next     = wipe_wr ? CRC_RESET :
                                       data_wr ? crc_calc :
                                       (crc_lo_wr | crc_hi_wr) ? crc_load :
                                       crc_reg;
   wire [BYTE_W-1:0]    lrc_next     = data_wr ? lrc_calc :
                                       lrc_wr  ? in_byte : lrc_reg;

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   wire                 ar_take      = arvalid & arready_reg;
   wire clc_sel_t       rsel         = clc_decode(araddr);
   // wipe bit and reserved bits always read as zero
   wire [DATA_W-1:0]    ctrl_rd      = DATA_W'(order_reg) << ORDER_BIT;
   wire [DATA_W-1:0]    rd_mux       = (rsel == SEL_CONTROL) ? ctrl_rd :
                                       (rsel == SEL_INPUT)   ? DATA_W'(byte_reg) :
                                       (rsel == SEL_CRC)     ? DATA_W'(crc_reg) :
                                       (rsel == SEL_LRC)     ? DATA_W'(lrc_reg) :
                                       RDATA_RESET;
   wire                 rvalid_next  = ar_take | (rvalid_reg & ~rready);
   wire [DATA_W-1:0]    rdata_next   = ar_take ? rd_mux : rdata_reg;
   wire [1:0]           rresp_next   = ar_take ? ((rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY)
                                               : rresp_reg;

   // ----------------------------------------------------------------
   // bus registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= RDATA_RESET;
      end else begin
         awready_reg <= ~aw_held_next;
         wready_reg  <= ~w_held_next;
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= ~rvalid_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   // address and data holding need no reset
   always_ff @(posedge mclk) begin
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
   end

   // ----------------------------------------------------------------
   // checksum engines
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         order_reg <= 1'b0;
         wipe_reg  <= 1'b0;
         byte_reg  <= BYTE_RESET;
         crc_reg   <= CRC_RESET;
         lrc_reg   <= LRC_RESET;
      end else begin
         order_reg <= order_next;
         wipe_reg  <= wipe_wr;
         byte_reg  <= byte_next;
         crc_reg   <= crc_next;
         lrc_reg   <= lrc_next;
      end
   end

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_wr_ready;
      aw_held_reg && w_held_reg && !bvalid_reg;
   endsequence

   sequence s_resp_out;
      bvalid_reg ##1 (bvalid_reg || $past(bready));
   endsequence

   crc_step_a: assert property (data_wr |=> crc_reg == $past(crc_calc))
      else $error("crc not updated from input byte");

   lrc_step_a: assert property (data_wr |=> lrc_reg == $past(lrc_calc))
      else $error("lrc not xored with input byte");

   msb_first_a: assert property (data_wr && !order_reg && crc_reg == CRC_RESET
                                 && in_byte == 8'h01 |=> crc_reg == CRC_POLY)
      else $error("msb first order wrong");

   lsb_first_a: assert property (data_wr && order_reg && crc_reg == CRC_RESET
                                 && in_byte == 8'h80 |=> crc_reg == CRC_POLY)
      else $error("lsb first order wrong");

   wipe_zero_a: assert property (wipe_wr |=> crc_reg == CRC_RESET ##1 !wipe_reg)
      else $error("wipe did not zero result or pulse stuck");

   crc_hold_a: assert property (!crc_touch |=> $stable(crc_reg))
      else $error("crc changed without cause");

   byte_load_a: assert property (crc_lo_wr && !crc_hi_wr |=>
                                 crc_reg[15:8] == $past(crc_reg[15:8])
                                 && crc_reg[7:0] == $past(wdata_reg[7:0]))
      else $error("byte load of crc result wrong");

   ctrl_read_a: assert property (ar_take && rsel == SEL_CONTROL |=>
                                 rvalid_reg && rdata_reg[DATA_W-1:ORDER_BIT+1] == '0
                                 && rdata_reg[0] == 1'b0)
      else $error("control reserved or wipe bit read nonzero");

   wr_resp_a: assert property (s_wr_ready |=> s_resp_out)
      else $error("write response missing");

   // ----------------------------------------------------------------
   // bus and register checks
   // ----------------------------------------------------------------
   sequence s_rd_taken;
      ar_take;
   endsequence

   sequence s_rd_out;
      rvalid_reg ##1 (rvalid_reg || $past(rready));
   endsequence

   rd_resp_a: assert property (s_rd_taken |=> s_rd_out)
      else $error("read response missing");

   aw_refuse_a: assert property (aw_held_reg |-> !awready_reg)
      else $error("address accepted while one is held");

   w_refuse_a: assert property (w_held_reg |-> !wready_reg)
      else $error("data accepted while one is held");

   ar_refuse_a: assert property (rvalid_reg |-> !arready_reg)
      else $error("read accepted while answer pending");

   b_hold_a: assert property (bvalid_reg && !bready |=>
                              bvalid_reg && $stable(bresp_reg))
      else $error("write response dropped early");

   r_hold_a: assert property (rvalid_reg && !rready |=>
                              rvalid_reg && $stable(rdata_reg) && $stable(rresp_reg))
      else $error("read response dropped early");

   lrc_hold_a: assert property (!data_wr && !lrc_wr |=> $stable(lrc_reg))
      else $error("lrc changed without cause");

   wipe_lrc_a: assert property (wipe_wr |=> $stable(lrc_reg))
      else $error("wipe disturbed lrc");

   lrc_load_a: assert property (lrc_wr |=> lrc_reg == $past(in_byte))
      else $error("lrc load wrong");

   order_set_a: assert property (ctrl_wr |=>
                                 order_reg == $past(wdata_reg[ORDER_BIT]))
      else $error("order bit not stored");

   order_only_a: assert property (ctrl_wr && !wipe_wr |=> $stable(crc_reg))
      else $error("order change altered result");

   full_load_a: assert property (crc_lo_wr && crc_hi_wr |=>
                                 crc_reg == $past(wdata_reg[CRC_W-1:0]))
      else $error("start value load wrong");

   zero_load_a: assert property (crc_lo_wr && crc_hi_wr
                                 && wdata_reg[CRC_W-1:0] == CRC_RESET |=> crc_reg == CRC_RESET)
      else $error("zero write did not clear result");

   unmapped_wr_a: assert property (commit && wsel == SEL_NONE |=>
                                   bresp_reg == RESP_SLVERR
                                   && $stable(crc_reg) && $stable(lrc_reg))
      else $error("unmapped write not refused");

   unmapped_rd_a: assert property (ar_take && rsel == SEL_NONE |=>
                                   rresp_reg == RESP_SLVERR && rdata_reg == RDATA_RESET)
      else $error("unmapped read not refused");

   crc_read_a: assert property (ar_take && rsel == SEL_CRC |=>
                                rdata_reg == DATA_W'($past(crc_reg)))
      else $error("crc read wrong");

   lrc_read_a: assert property (ar_take && rsel == SEL_LRC |=>
                                rdata_reg == DATA_W'($past(lrc_reg)))
      else $error("lrc read wrong");

   byte_read_a: assert property (ar_take && rsel == SEL_INPUT |=>
                                 rdata_reg == DATA_W'($past(byte_reg)))
      else $error("input byte read wrong");

endmodule

// ==== logic/clc_pkg.sv ====
package clc_pkg;

   // ----------------------------------------------------------------
   // bus shape
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int STRB_W = DATA_W / 8;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CHECKSUM_CONTROL    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CHECKSUM_INPUT_BYTE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CRC_RESULT_VALUE    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_LRC_RESULT_VALUE    = 8'h18;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ORDER_BIT = 1;
   localparam int WIPE_BIT  = 2;
   localparam int BYTE_W    = 8;
   localparam int CRC_W     = 16;

   localparam logic [CRC_W-1:0]  CRC_POLY      = 16'h8005;
   localparam logic [CRC_W-1:0]  CRC_RESET     = 16'h0000;
   localparam logic [BYTE_W-1:0] LRC_RESET     = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RESET   = 32'h00000000;

   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_CONTROL,
      SEL_INPUT,
      SEL_CRC,
      SEL_LRC,
      SEL_NONE
   } clc_sel_t;

endpackage

// ==== testbench/crc16_lrc_checker_test.sv ====
`timescale 1ns/1ns
module crc16_lrc_checker_test;
   import clc_pkg::*;
   logic              mclk;
   logic              resetn;
   logic [ADDR_W-1:0] awaddr;
   logic              awvalid;
   logic              awready;
   logic [DATA_W-1:0] wdata;
   logic [STRB_W-1:0] wstrb;
   logic              wvalid;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready;
   logic [ADDR_W-1:0] araddr;
   logic              arvalid;
   logic              arready;
   logic [DATA_W-1:0] rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready;
   logic [1:0]        exp_b[$];
   logic [33:0]       exp_r[$];
   logic [31:0]       seed = 32'd26154;
   logic [3:0]        strbs[3] = '{4'h1, 4'h3, 4'hF};
   int                n_mismatch = 0;
   int                n_tests = 0;

   clc_checker i_dut (.mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // bit-serial reference, msb or lsb of the byte first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                            input logic lsb);
      logic fb;
      for (int i = 0; i < 8; i++) begin
         fb = c[15] ^ (lsb ? d[i] : d[7-i]);
         c = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
      return c;
   endfunction

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] e);
      exp_b.push_back(e);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      exp_r.push_back({e, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // response monitor
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      if (bvalid === 1'b1 && bready === 1'b1)
         chk({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      if (rvalid === 1'b1 && rready === 1'b1)
         chk({rresp, rdata}, exp_r.pop_front());
   end

   initial begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [15:0] crc;
      logic [7:0]  lrc;
      string       txt;
      txt = "123456789";
      {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      rd(OFS_CHECKSUM_CONTROL, 32'h0, RESP_OKAY);
      rd(OFS_CHECKSUM_INPUT_BYTE, 32'h0, RESP_OKAY);
      rd(OFS_CRC_RESULT_VALUE, 32'h0, RESP_OKAY);
      rd(OFS_LRC_RESULT_VALUE, 32'h0, RESP_OKAY);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      wr(8'h00, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      wr(OFS_CHECKSUM_CONTROL, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rd(OFS_CHECKSUM_CONTROL, 32'h2, RESP_OKAY);
      // check string, msb first
      wr(OFS_CHECKSUM_CONTROL, 32'h4, 4'h1, RESP_OKAY);
      wr(OFS_LRC_RESULT_VALUE, 32'h0, 4'h1, RESP_OKAY);
      for (int i = 0; i < 9; i++) wr(OFS_CHECKSUM_INPUT_BYTE, {24'h0, txt[i]}, 4'h1, RESP_OKAY);
      rd(OFS_CRC_RESULT_VALUE, 32'h0000FEE8, RESP_OKAY);
      for (int o = 0; o < 2; o++) begin
         wr(OFS_CHECKSUM_CONTROL, {29'h0, 1'b1, o[0], 1'b0}, 4'hF, RESP_OKAY);
         rd(OFS_CRC_RESULT_VALUE, 32'h0, RESP_OKAY);
         rd(OFS_CHECKSUM_CONTROL, {30'h0, o[0], 1'b0}, RESP_OKAY);
         r = next_rand();
         lrc = r[7:0];
         wr(OFS_LRC_RESULT_VALUE, {24'h0, lrc}, 4'h1, RESP_OKAY);
         crc = 16'h0000;
         for (int k = 0; k < 6; k++) begin
            r = next_rand();
            // first byte after a wipe: single feedback tap on the last bit
            if (k == 0) r[7:0] = o[0] ? 8'h80 : 8'h01;
            wr(OFS_CHECKSUM_INPUT_BYTE, r, strbs[k % 3], RESP_OKAY);
            crc = crc_step(crc, r[7:0], o[0]);
            lrc = lrc ^ r[7:0];
            rd(OFS_CRC_RESULT_VALUE, {16'h0, crc}, RESP_OKAY);
            rd(OFS_LRC_RESULT_VALUE, {24'h0, lrc}, RESP_OKAY);
            rd(OFS_CHECKSUM_INPUT_BYTE, {24'h0, r[7:0]}, RESP_OKAY);
         end
         // start value loaded one lane at a time
         r = next_rand();
         wr(OFS_CRC_RESULT_VALUE, r, 4'h1, RESP_OKAY);
         crc = {crc[15:8], r[7:0]};
         rd(OFS_CRC_RESULT_VALUE, {16'h0, crc}, RESP_OKAY);
         wr(OFS_CRC_RESULT_VALUE, r, 4'h2, RESP_OKAY);
         crc = r[15:0];
         rd(OFS_CRC_RESULT_VALUE, {16'h0, crc}, RESP_OKAY);
         wr(OFS_CHECKSUM_INPUT_BYTE, r, 4'hE, RESP_OKAY);
         rd(OFS_CRC_RESULT_VALUE, {16'h0, crc}, RESP_OKAY);
         wr(OFS_CHECKSUM_INPUT_BYTE, {r[31:8], r[23:16]}, 4'h1, RESP_OKAY);
         crc = crc_step(crc, r[23:16], o[0]);
         rd(OFS_CRC_RESULT_VALUE, {16'h0, crc}, RESP_OKAY);
         wr(OFS_CRC_RESULT_VALUE, 32'h0, 4'hF, RESP_OKAY);
         rd(OFS_CRC_RESULT_VALUE, 32'h0, RESP_OKAY);
      end
      // reset again in mid-run: every register back to zero
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rd(OFS_CHECKSUM_CONTROL, 32'h0, RESP_OKAY);
      rd(OFS_CRC_RESULT_VALUE, 32'h0, RESP_OKAY);
      rd(OFS_LRC_RESULT_VALUE, 32'h0, RESP_OKAY);
      rd(OFS_CHECKSUM_INPUT_BYTE, 32'h0, RESP_OKAY);
      wrap_up();
   end
endmodule
